// ---- sfcf_consts.svh ----
/*
 Constants of the serial flash command front end: opcodes, bit counts,
 field positions and pin-enable patterns.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SFCF_CONSTS_SVH
`define SFCF_CONSTS_SVH
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FREAD 8'h0b
`define SFCF_OP_PP 8'h02
`define SFCF_OP_SE 8'h20
`define SFCF_OP_BE 8'hd8
`define SFCF_OP_CE_A 8'h60
`define SFCF_OP_CE_B 8'hc7
`define SFCF_OP_QENTER 8'h35
`define SFCF_OP_QEXIT 8'hf5
`define SFCF_BYTE_BITS 6'h08
`define SFCF_STEP_ONE 6'h01
`define SFCF_STEP_QUAD 6'h04
`define SFCF_DUMMY_SPI 6'h08
`define SFCF_DUMMY_QPI 6'h04
`define SFCF_BLK_LSB 16
`define SFCF_SECT_LSB 12
`define SFCF_OE_NONE 4'h0
`define SFCF_OE_SI 4'h1
`define SFCF_OE_SO 4'h2
`define SFCF_OE_ALL 4'hf
`define SFCF_SEC_OPC 3'h0
`define SFCF_SEC_ADDR 3'h1
`define SFCF_SEC_DUMMY 3'h2
`define SFCF_SEC_WR 3'h3
`define SFCF_SEC_RD 3'h4
`define SFCF_SEC_END 3'h5
`endif

// ---- sfcf_pkg.sv ----
/*
 Types of the serial flash command front end: state encodings.
 Assumes nothing of its surroundings.
*/
package sfcf_pkg;
    typedef enum logic [2:0] {
        SFCF_ST_OPC = 3'b000,
        SFCF_ST_ADDR = 3'b001,
        SFCF_ST_DUMMY = 3'b011,
        SFCF_ST_DOUT = 3'b010,
        SFCF_ST_DIN = 3'b110,
        SFCF_ST_STBY = 3'b100
    } sfcf_dev_st_t;
    typedef enum logic [1:0] {
        SFCF_H_IDLE = 2'b00,
        SFCF_H_RUN = 2'b01,
        SFCF_H_TAIL = 2'b11,
        SFCF_H_GAP = 2'b10
    } sfcf_host_st_t;
endpackage

// ---- sfcf_if.sv ----
/*
 Serial link between flash controller and flash device.
 Assumes both ends drive only output and enable; the wire level of each
 data line is resolved here, idle lines float high.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfcf_if;
    logic cs_n;
    logic sclk;
    logic [3:0] host_o;
    logic [3:0] host_oe;
    logic [3:0] dev_o;
    logic [3:0] dev_oe;
    logic [3:0] io;
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_line
        assign io[g] = dev_oe[g] ? dev_o[g] : (host_oe[g] ? host_o[g] : 1'b1);
    end
    modport dev (input cs_n, input sclk, input io, output dev_o,
        output dev_oe);
    modport host (output cs_n, output sclk, output host_o, output host_oe,
        input io);
endinterface
`default_nettype wire

// ---- sfcf_sync.sv ----
/*
 Two-flop level synchroniser, parameterised width.
 Assumes each bit is a level that is stable long enough to be caught.
*/
`timescale 1ns/1ps
`default_nettype none
module sfcf_sync #(
    parameter int W = 1
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else if (en)
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- sfcf_device.sv ----
/*
 Flash device command front end: decodes frames on the link clock, keeps
 the four-line mode and the lock bits, and hands write-type array
 commands to the core clock domain.
 Assumes the host keeps select high between frames long enough for the
 core clock to see it, and holds rd_byte stable while a read streams.
*/
// Functional notes
// - Unknown opcode: standby until select rises
// - Standby keeps data output high impedance
// - Valid opcode: active until select rises
// - Sample on rising, shift on falling edge
// - Host uses clock mode 0 or 3
// - Idle clock level selects the mode
// - Read data may stop after any bit
// - Write-type commands need byte-aligned select rise
// - Array access ignored while operation busy
// - Host checks status before each command; sfcf_host sends each request without a status read
// - Opcode 35h enters four-line mode
// - Four-line mode uses all four lines
// - Lock granularity is one 64K block
// - Boundary blocks lock per 4K sector
// - Opcode F5h returns to single-line mode
`include "sfcf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sfcf_device #(
    parameter int ADDR_W = 24,
    parameter int BLK_CNT = 128,
    parameter int SECT_N = 16,
    parameter logic [7:0] RDSR_OP = 8'h05,
    parameter logic [7:0] LOCK_OP = 8'h36,
    parameter logic [7:0] UNLOCK_OP = 8'h39
)(
    sfcf_if.dev link,
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic op_busy,
    input wire logic [7:0] rd_byte,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic quad_mode
);
    import sfcf_pkg::*;
    localparam int BLK_W = $clog2(BLK_CNT);
    localparam int SECT_W = $clog2(SECT_N);
    localparam int LOCK_N = BLK_CNT - 2 + 2 * SECT_N;
    localparam int IDX_W = $clog2(LOCK_N);
    localparam logic [BLK_W-1:0] BLK_TOP = BLK_W'(BLK_CNT - 1);
    localparam logic [5:0] ADDR_BITS = 6'(ADDR_W);

    sfcf_dev_st_t st_reg, st_next;
    logic [5:0] cnt_reg, cnt_next, step;
    logic [ADDR_W-1:0] sr_reg, sr_next, addr_hold_reg;
    logic [7:0] op_hold_reg, out_sr_reg, out_byte;
    logic [2:0] out_cnt_reg;
    logic [LOCK_N-1:0] lock_reg;
    logic [BLK_W-1:0] blk;
    logic started_reg, ok_reg, ok_next, arm_now, armed_reg;
    logic quad_reg, quad_eff, locked, busy_s, cs_s, quad_s, cs_prev_reg;
    logic [7:0] rd_s;
    logic frame_rst_n;

    function automatic logic has_addr(input logic [7:0] op);
        has_addr = op == `SFCF_OP_READ || op == `SFCF_OP_FREAD ||
            op == `SFCF_OP_PP || op == `SFCF_OP_SE || op == `SFCF_OP_BE ||
            op == LOCK_OP || op == UNLOCK_OP;
    endfunction
    function automatic logic is_array(input logic [7:0] op);
        is_array = op == `SFCF_OP_READ || op == `SFCF_OP_FREAD ||
            op == `SFCF_OP_PP || op == `SFCF_OP_SE || op == `SFCF_OP_BE ||
            op == `SFCF_OP_CE_A || op == `SFCF_OP_CE_B;
    endfunction
    function automatic logic is_write(input logic [7:0] op);
        is_write = op == `SFCF_OP_PP || op == `SFCF_OP_SE ||
            op == `SFCF_OP_BE || op == `SFCF_OP_CE_A ||
            op == `SFCF_OP_CE_B || op == `SFCF_OP_QENTER ||
            op == `SFCF_OP_QEXIT || op == LOCK_OP || op == UNLOCK_OP;
    endfunction
    // Normal read has no four-line form
    function automatic logic known(input logic [7:0] op, input logic q);
        known = (has_addr(op) && !(q && op == `SFCF_OP_READ)) ||
            is_write(op) || op == RDSR_OP;
    endfunction
    function automatic logic [IDX_W-1:0] lock_idx(input logic [ADDR_W-1:0] a);
        logic [BLK_W-1:0] b;
        logic [SECT_W-1:0] s;
        b = a[`SFCF_BLK_LSB +: BLK_W];
        s = a[`SFCF_SECT_LSB +: SECT_W];
        if (b == '0)
            lock_idx = IDX_W'(s);
        else if (b == BLK_TOP)
            lock_idx = IDX_W'(SECT_N + int'(s));
        else
            lock_idx = IDX_W'(2 * SECT_N + int'(b) - 1);
    endfunction

    // Select high clears all frame state without a clock edge
    assign frame_rst_n = reset_n & ~link.cs_n;

    sfcf_sync #(.W(9)) u_link_sync (
        .clk(link.sclk),
        .rst_n(reset_n),
        .en(1'b1),
        .d({op_busy, rd_byte}),
        .q({busy_s, rd_s})
    );

    // Mode and lock commands of the last frame take effect on the next frame's first edge
    always_comb
    begin
        quad_eff = quad_reg;
        if (!started_reg && armed_reg && op_hold_reg == `SFCF_OP_QENTER)
            quad_eff = 1'b1;
        if (!started_reg && armed_reg && op_hold_reg == `SFCF_OP_QEXIT)
            quad_eff = 1'b0;
        step = quad_eff ? `SFCF_STEP_QUAD : `SFCF_STEP_ONE;
        sr_next = quad_eff ? {sr_reg[ADDR_W-5:0], link.io} :
            {sr_reg[ADDR_W-2:0], link.io[0]};
        cnt_next = cnt_reg + step;
        blk = sr_next[`SFCF_BLK_LSB +: BLK_W];
        if (op_hold_reg == `SFCF_OP_BE && blk == '0)
            locked = |lock_reg[SECT_N-1:0];
        else if (op_hold_reg == `SFCF_OP_BE && blk == BLK_TOP)
            locked = |lock_reg[2*SECT_N-1:SECT_N];
        else
            locked = lock_reg[lock_idx(sr_next)];
        st_next = st_reg;
        ok_next = ok_reg;
        unique case (st_reg)
            SFCF_ST_OPC:
                if (cnt_next == `SFCF_BYTE_BITS)
                begin
                    cnt_next = '0;
                    ok_next = is_write(sr_next[7:0]) &&
                        !has_addr(sr_next[7:0]) &&
                        !(is_array(sr_next[7:0]) && |lock_reg);
                    if (!known(sr_next[7:0], quad_eff))
                        st_next = SFCF_ST_STBY;
                    else if (is_array(sr_next[7:0]) && busy_s)
                        st_next = SFCF_ST_STBY;
                    else if (has_addr(sr_next[7:0]))
                        st_next = SFCF_ST_ADDR;
                    else if (sr_next[7:0] == RDSR_OP)
                        st_next = SFCF_ST_DOUT;
                    else
                        st_next = SFCF_ST_DIN;
                end
            SFCF_ST_ADDR:
                if (cnt_next == ADDR_BITS)
                begin
                    cnt_next = '0;
                    ok_next = is_write(op_hold_reg) && (!locked ||
                        op_hold_reg == LOCK_OP || op_hold_reg == UNLOCK_OP);
                    if (op_hold_reg == `SFCF_OP_READ)
                        st_next = SFCF_ST_DOUT;
                    else if (op_hold_reg == `SFCF_OP_FREAD)
                        st_next = SFCF_ST_DUMMY;
                    else
                        st_next = SFCF_ST_DIN;
                end
            SFCF_ST_DUMMY:
            begin
                cnt_next = cnt_reg + `SFCF_STEP_ONE;
                if (cnt_next == (quad_eff ? `SFCF_DUMMY_QPI : `SFCF_DUMMY_SPI))
                    st_next = SFCF_ST_DOUT;
            end
            SFCF_ST_DOUT, SFCF_ST_STBY:
                cnt_next = cnt_reg;
            SFCF_ST_DIN:
                cnt_next = cnt_reg + step;
        endcase
        arm_now = ok_next && st_next == SFCF_ST_DIN &&
            (st_reg != SFCF_ST_DIN || cnt_next[2:0] == 3'h0);
    end

    always_ff @(posedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            st_reg <= SFCF_ST_OPC;
            cnt_reg <= '0;
            sr_reg <= '0;
            ok_reg <= 1'b0;
            started_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sr_reg <= sr_next;
            ok_reg <= ok_next;
            started_reg <= 1'b1;
        end
    end

    // Survives select; cleared only by reset
    always_ff @(posedge link.sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            quad_reg <= 1'b0;
            armed_reg <= 1'b0;
            op_hold_reg <= '0;
            addr_hold_reg <= '0;
        end
        else
        begin
            quad_reg <= quad_eff;
            armed_reg <= arm_now;
            if (st_reg == SFCF_ST_OPC && st_next != SFCF_ST_OPC)
                op_hold_reg <= sr_next[7:0];
            if (st_reg == SFCF_ST_ADDR && st_next != SFCF_ST_ADDR)
                addr_hold_reg <= sr_next;
        end
    end

    always_ff @(posedge link.sclk or negedge reset_n)
    begin
        if (!reset_n)
            lock_reg <= '0;
        else if (!started_reg && armed_reg && op_hold_reg == LOCK_OP)
            lock_reg[lock_idx(addr_hold_reg)] <= 1'b1;
        else if (!started_reg && armed_reg && op_hold_reg == UNLOCK_OP)
            lock_reg[lock_idx(addr_hold_reg)] <= 1'b0;
    end

    always_comb
    begin
        if (out_cnt_reg != 3'h0)
            out_byte = out_sr_reg;
        else if (op_hold_reg == RDSR_OP)
            out_byte = {6'h00, quad_reg, busy_s};
        else
            out_byte = rd_s;
    end

    // Select rise releases the lines at once, whatever bit was out
    always_ff @(negedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            out_sr_reg <= '0;
            out_cnt_reg <= '0;
            link.dev_o <= '0;
            link.dev_oe <= `SFCF_OE_NONE;
        end
        else if (st_reg == SFCF_ST_DOUT && quad_reg)
        begin
            link.dev_o <= out_byte[7:4];
            link.dev_oe <= `SFCF_OE_ALL;
            out_sr_reg <= {out_byte[3:0], 4'h0};
            out_cnt_reg <= out_cnt_reg + 3'h4;
        end
        else if (st_reg == SFCF_ST_DOUT)
        begin
            link.dev_o <= {2'h0, out_byte[7], 1'b0};
            link.dev_oe <= `SFCF_OE_SO;
            out_sr_reg <= {out_byte[6:0], 1'b0};
            out_cnt_reg <= out_cnt_reg + 3'h1;
        end
        else
            link.dev_oe <= `SFCF_OE_NONE;
    end

    sfcf_sync #(.W(2)) u_core_sync (
        .clk(core_clk),
        .rst_n(reset_n),
        .en(clk_en),
        .d({link.cs_n, quad_reg}),
        .q({cs_s, quad_s})
    );

    // Hold registers are quiet once select is high: the synced rise qualifies
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_prev_reg <= 1'b1;
            cmd_valid <= 1'b0;
            cmd_opcode <= '0;
            cmd_addr <= '0;
            quad_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_prev_reg <= cs_s;
            quad_mode <= quad_s;
            cmd_valid <= cs_s && !cs_prev_reg && armed_reg &&
                is_array(op_hold_reg);
            if (cs_s && !cs_prev_reg)
            begin
                cmd_opcode <= op_hold_reg;
                cmd_addr <= addr_hold_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sfcf_host.sv ----
/*
 Flash controller end: runs one frame per request, making the link clock
 by dividing core_clk, and returns read bytes.
 Assumes the user requests only what the device understands.
*/
`include "sfcf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sfcf_host #(
    parameter int HALF = 20,
    parameter bit CPOL = 1'b0,
    parameter int ADDR_W = 24
)(
    sfcf_if.host link,
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic [7:0] req_opcode,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_has_addr,
    input wire logic [5:0] req_dummy,
    input wire logic [7:0] req_wr_cnt,
    input wire logic [7:0] req_wr_data,
    input wire logic [7:0] req_rd_cnt,
    output logic req_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic quad_mode
);
    import sfcf_pkg::*;
    localparam int TX_W = ADDR_W + 8;
    localparam int DIV_W = $clog2(HALF) + 1;
    sfcf_host_st_t st_reg;
    logic [DIV_W-1:0] div_reg;
    logic [2:0] sec_reg, sec_nx;
    logic [5:0] left_reg, left_dec;
    logic [7:0] bytes_reg, op_reg, wr_reg, wr_cnt_reg, rd_cnt_reg, rx_new;
    logic [TX_W-1:0] tx_reg;
    logic [5:0] dummy_reg;
    logic has_addr_reg, tick, drive;
    logic [3:0] io_s;

    sfcf_sync #(.W(4)) u_io_sync (
        .clk(core_clk),
        .rst_n(reset_n),
        .en(clk_en),
        .d(link.io),
        .q(io_s)
    );

    always_comb
    begin
        tick = div_reg == DIV_W'(HALF - 1);
        left_dec = left_reg - ((sec_reg == `SFCF_SEC_DUMMY || !quad_mode) ?
            `SFCF_STEP_ONE : `SFCF_STEP_QUAD);
        rx_new = quad_mode ? {rd_data[3:0], io_s} : {rd_data[6:0], io_s[1]};
        sec_nx = `SFCF_SEC_END;
        if (sec_reg < `SFCF_SEC_ADDR && has_addr_reg)
            sec_nx = `SFCF_SEC_ADDR;
        else if (sec_reg < `SFCF_SEC_DUMMY && dummy_reg != '0)
            sec_nx = `SFCF_SEC_DUMMY;
        else if (sec_reg < `SFCF_SEC_WR && wr_cnt_reg != '0)
            sec_nx = `SFCF_SEC_WR;
        else if (sec_reg < `SFCF_SEC_RD && rd_cnt_reg != '0)
            sec_nx = `SFCF_SEC_RD;
        drive = sec_reg == `SFCF_SEC_OPC || sec_reg == `SFCF_SEC_ADDR ||
            sec_reg == `SFCF_SEC_WR;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg <= SFCF_H_IDLE;
            div_reg <= '0;
            link.cs_n <= 1'b1;
            link.sclk <= CPOL;
            link.host_o <= '0;
            link.host_oe <= `SFCF_OE_NONE;
            req_ready <= 1'b0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            quad_mode <= 1'b0;
            sec_reg <= `SFCF_SEC_OPC;
            left_reg <= '0;
            bytes_reg <= '0;
            tx_reg <= '0;
            op_reg <= '0;
            wr_reg <= '0;
            wr_cnt_reg <= '0;
            rd_cnt_reg <= '0;
            dummy_reg <= '0;
            has_addr_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid <= 1'b0;
            div_reg <= (st_reg == SFCF_H_IDLE || tick) ? '0 : div_reg + 1'b1;
            unique case (st_reg)
                SFCF_H_IDLE:
                begin
                    req_ready <= !(req_valid && req_ready);
                    if (req_valid && req_ready)
                    begin
                        st_reg <= SFCF_H_RUN;
                        link.cs_n <= 1'b0;
                        link.sclk <= 1'b0;
                        tx_reg <= {req_opcode, req_addr};
                        link.host_o <= quad_mode ? req_opcode[7:4] :
                            {3'h0, req_opcode[7]};
                        link.host_oe <= quad_mode ? `SFCF_OE_ALL : `SFCF_OE_SI;
                        sec_reg <= `SFCF_SEC_OPC;
                        bytes_reg <= 8'h01;
                        left_reg <= `SFCF_BYTE_BITS;
                        op_reg <= req_opcode;
                        wr_reg <= req_wr_data;
                        wr_cnt_reg <= req_wr_cnt;
                        rd_cnt_reg <= req_rd_cnt;
                        dummy_reg <= req_dummy;
                        has_addr_reg <= req_has_addr;
                    end
                end
                SFCF_H_RUN:
                    if (tick && !link.sclk)
                    begin
                        link.sclk <= 1'b1;
                        tx_reg <= quad_mode ? {tx_reg[TX_W-5:0], 4'h0} :
                            {tx_reg[TX_W-2:0], 1'b0};
                        left_reg <= left_dec;
                        if (sec_reg == `SFCF_SEC_RD)
                            rd_data <= rx_new;
                        if (sec_reg == `SFCF_SEC_RD && left_dec == '0)
                            rd_valid <= 1'b1;
                        if (left_dec == '0 && bytes_reg > 8'h01)
                        begin
                            bytes_reg <= bytes_reg - 8'h01;
                            left_reg <= `SFCF_BYTE_BITS;
                            tx_reg <= {wr_reg, {ADDR_W{1'b0}}};
                        end
                        else if (left_dec == '0)
                        begin
                            sec_reg <= sec_nx;
                            if (sec_nx == `SFCF_SEC_WR)
                                tx_reg <= {wr_reg, {ADDR_W{1'b0}}};
                            left_reg <= sec_nx == `SFCF_SEC_ADDR ? 6'(ADDR_W) :
                                sec_nx == `SFCF_SEC_DUMMY ? dummy_reg :
                                `SFCF_BYTE_BITS;
                            bytes_reg <= sec_nx == `SFCF_SEC_WR ? wr_cnt_reg :
                                sec_nx == `SFCF_SEC_RD ? rd_cnt_reg : 8'h01;
                            if (sec_nx == `SFCF_SEC_END)
                                st_reg <= SFCF_H_TAIL;
                        end
                    end
                    else if (tick)
                    begin
                        link.sclk <= 1'b0;
                        link.host_o <= quad_mode ? tx_reg[TX_W-1 -: 4] :
                            {3'h0, tx_reg[TX_W-1]};
                        link.host_oe <= !quad_mode ? `SFCF_OE_SI :
                            (drive ? `SFCF_OE_ALL : `SFCF_OE_NONE);
                    end
                SFCF_H_TAIL:
                    if (tick && link.sclk != CPOL)
                        link.sclk <= CPOL;
                    else if (tick)
                    begin
                        link.cs_n <= 1'b1;
                        link.host_oe <= `SFCF_OE_NONE;
                        st_reg <= SFCF_H_GAP;
                        if (op_reg == `SFCF_OP_QENTER)
                            quad_mode <= 1'b1;
                        if (op_reg == `SFCF_OP_QEXIT)
                            quad_mode <= 1'b0;
                    end
                SFCF_H_GAP:
                    if (tick)
                    begin
                        st_reg <= SFCF_H_IDLE;
                        req_ready <= 1'b1;
                    end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sfcf_link_props.sv ----
/*
 Link checks between the two ends, sampled on core_clk.
 Assumes the host runs with CPOL as given and a half period of 4.
*/
`include "sfcf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sfcf_link_props #(
    parameter bit CPOL = 1'b1
)(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] host_o,
    input wire logic [3:0] host_oe,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] io
);
    logic sclk_reg;
    logic [7:0] rise_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            sclk_reg <= CPOL;
        else
            sclk_reg <= sclk;
    end
    // Counts link clock rises within one frame
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || cs_n)
            rise_reg <= 8'h00;
        else if (sclk && !sclk_reg)
            rise_reg <= rise_reg + 8'h01;
    end
    property p_idle_rel; cs_n |-> dev_oe == `SFCF_OE_NONE; endproperty
    a_idle_rel: assert property (p_idle_rel)
        else $error("device drives while deselected");
    property p_dev_edge; $changed(dev_o) && !cs_n |-> $fell(sclk); endproperty
    a_dev_edge: assert property (p_dev_edge)
        else $error("device output moved off falling edge");
    property p_idle_clk; cs_n && $past(cs_n) |-> sclk == CPOL; endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("idle clock level wrong");
    property p_half; !cs_n && $changed(sclk) |=> $stable(sclk)[*3];
    endproperty
    a_half: assert property (p_half)
        else $error("link clock half period too short");
    property p_gap; $rose(cs_n) |-> cs_n[*4]; endproperty
    a_gap: assert property (p_gap)
        else $error("select high gap too short");
    property p_byte_end; $rose(cs_n) |-> rise_reg[0] == 1'b0; endproperty
    a_byte_end: assert property (p_byte_end)
        else $error("select rose inside a byte");
    property p_late; dev_oe != `SFCF_OE_NONE |-> rise_reg >= 8'h02;
    endproperty
    a_late: assert property (p_late)
        else $error("device drove before opcode done");
    property p_clash; (dev_oe & host_oe) == `SFCF_OE_NONE; endproperty
    a_clash: assert property (p_clash)
        else $error("both ends drive one line");
    c_frame: cover property ($rose(cs_n));
    c_single: cover property (dev_oe == `SFCF_OE_SO);
    c_quad: cover property (dev_oe == `SFCF_OE_ALL);
endmodule
`default_nettype wire

// ---- sfcf_tb_top.sv ----
/*
 Bench joining host and device ends through the link interface.
 Assumes mode 3 and a half period of 4 core cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sfcf_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_opcode = 8'h00;
    logic [23:0] req_addr = 24'h000000;
    logic req_has_addr = 1'b0;
    logic [5:0] req_dummy = 6'h00;
    logic [7:0] req_rd_cnt = 8'h00;
    logic op_busy = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] req_wr_cnt = 8'h00;
    logic [7:0] rd_byte = 8'h5a;
    logic req_ready, rd_valid, cmd_valid, h_quad, d_quad;
    logic [7:0] rd_data, cmd_opcode;
    logic [7:0] last_rd = 8'h33;
    logic [23:0] cmd_addr;
    logic [31:0] last_cmd;
    int n_cmd = 0;
    int fail_count = 0;
    int n_compared = 0;
    sfcf_if sfcf_if_i ();
    sfcf_host #(.HALF(4), .CPOL(1'b1)) sfcf_host_i (.link(sfcf_if_i),
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .req_valid(req_valid), .req_opcode(req_opcode), .req_addr(req_addr),
        .req_has_addr(req_has_addr), .req_dummy(req_dummy),
        .req_wr_cnt(req_wr_cnt), .req_wr_data(8'h00), .req_rd_cnt(req_rd_cnt),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .quad_mode(h_quad));
    sfcf_device sfcf_device_i (.link(sfcf_if_i), .core_clk(core_clk),
        .reset_n(reset_n), .clk_en(clk_en), .op_busy(op_busy),
        .rd_byte(rd_byte), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_addr(cmd_addr), .quad_mode(d_quad));
    sfcf_link_props #(.CPOL(1'b1)) sfcf_link_props_i (.core_clk(core_clk),
        .reset_n(reset_n), .cs_n(sfcf_if_i.cs_n), .sclk(sfcf_if_i.sclk),
        .host_o(sfcf_if_i.host_o), .host_oe(sfcf_if_i.host_oe),
        .dev_o(sfcf_if_i.dev_o), .dev_oe(sfcf_if_i.dev_oe),
        .io(sfcf_if_i.io));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (rd_valid === 1'b1)
            last_rd <= rd_data;
        if (cmd_valid === 1'b1)
        begin
            last_cmd <= {cmd_opcode, cmd_addr};
            n_cmd <= n_cmd + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Whole frame; the tail wait lets the core see the select rise
    task automatic xf(input logic [7:0] op, input logic [23:0] a,
        input logic [5:0] dm, input logic [7:0] rc);
        @(negedge core_clk);
        req_valid = 1'b1;
        req_opcode = op;
        req_addr = a;
        req_has_addr = (a != 24'hffffff);
        req_dummy = dm;
        req_rd_cnt = rc;
        while (req_ready !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1)
            @(negedge core_clk);
        repeat (8) @(negedge core_clk);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        chk(d_quad, 1'b0);
        xf(8'h05, 24'hffffff, 6'h00, 8'h01);
        chk(last_rd, 8'h00);
        xf(8'h03, 24'h000100, 6'h00, 8'h02);
        chk(last_rd, 8'h5a);
        xf(8'hab, 24'hffffff, 6'h00, 8'h01);
        chk(last_rd, 8'hff);
        xf(8'h20, 24'h012000, 6'h00, 8'h00);
        chk(last_cmd, 32'h20012000);
        op_busy = 1'b1;
        xf(8'h05, 24'hffffff, 6'h00, 8'h01);
        chk(last_rd, 8'h01);
        xf(8'h03, 24'h000100, 6'h00, 8'h01);
        chk(last_rd, 8'hff);
        xf(8'h20, 24'h030000, 6'h00, 8'h00);
        chk(n_cmd, 1);
        op_busy = 1'b0;
        xf(8'h36, 24'h001000, 6'h00, 8'h00);
        xf(8'h20, 24'h001000, 6'h00, 8'h00);
        chk(n_cmd, 1);
        xf(8'h20, 24'h002000, 6'h00, 8'h00);
        chk(last_cmd, 32'h20002000);
        xf(8'h36, 24'h020000, 6'h00, 8'h00);
        xf(8'h20, 24'h025000, 6'h00, 8'h00);
        chk(n_cmd, 2);
        xf(8'hd8, 24'h7f0000, 6'h00, 8'h00);
        chk(last_cmd, 32'hd87f0000);
        xf(8'h39, 24'h020000, 6'h00, 8'h00);
        xf(8'h20, 24'h025000, 6'h00, 8'h00);
        chk(last_cmd, 32'h20025000);
        xf(8'h35, 24'hffffff, 6'h00, 8'h00);
        xf(8'h05, 24'hffffff, 6'h00, 8'h01);
        chk(last_rd, 8'h02);
        chk({h_quad, d_quad}, 2'h3);
        rd_byte = 8'hc3;
        xf(8'h0b, 24'h000040, 6'h04, 8'h01);
        chk(last_rd, 8'hc3);
        xf(8'h03, 24'h000040, 6'h00, 8'h01);
        chk(last_rd, 8'hff);
        xf(8'hf5, 24'hffffff, 6'h00, 8'h00);
        xf(8'h05, 24'hffffff, 6'h00, 8'h01);
        chk({last_rd, d_quad}, 9'h000);
        clk_en = 1'b0;
        xf(8'h02, 24'h003000, 6'h00, 8'h00);
        clk_en = 1'b1;
        chk(n_cmd, 4);
        req_wr_cnt = 8'h01;
        xf(8'h02, 24'h003000, 6'h00, 8'h00);
        chk(last_cmd, 32'h02003000);
        give_verdict();
    end
endmodule
`default_nettype wire
